// ===== verilog/ewg_pkg.sv
// ewg_pkg: constants of the eeprom write guard and hold block
// assumes one 200 MHz system clock; serial pins are asynchronous to it
package ewg_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SYNC_STAGES = 2;

  // ****************************************
  // array geometry
  // ****************************************
  localparam int ADDR_W = 13;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

  // ****************************************
  // frame lengths in serial clocks
  // ****************************************
  localparam logic [5:0] LEN_SHORT_CMD = 6'h08;
  localparam logic [5:0] LEN_STATUS_WRITE = 6'h10;
  localparam logic [5:0] LEN_ARRAY_HDR = 6'h20;
  localparam logic [5:0] LEN_ARRAY_WRAP = 6'h28;
  localparam logic [5:0] LEN_ADDR_END = 6'h18;

  // ****************************************
  // status byte layout and reset values
  // ****************************************
  localparam int SR_LOCK_POS = 7;
  localparam int SR_BP_HI_POS = 3;
  localparam int SR_BP_LO_POS = 2;
  localparam int SR_WEL_POS = 1;
  localparam int SR_WIP_POS = 0;
  localparam logic RST_LOCK = 1'b0;
  localparam logic [1:0] RST_BP = 2'h0;

  // ****************************************
  // protect size codes
  // ****************************************
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;

  // ****************************************
  // internal write cycle length in clocks
  // ****************************************
  localparam int WRITE_CYCLES = 1000;

endpackage

// ===== verilog/ewg_write_guard.sv
// ewg_write_guard: protection, hold and write-enable logic of a serial eeprom
// assumes: serial pins arrive asynchronously; lowSupply comes from the
// supply detector; array timing and data storage live outside this block
`timescale 1ns/100ps
`default_nettype none

module ewg_write_guard #(
  parameter bit WIDE64 = 1'b1,
  parameter int WRITE_CYC = ewg_pkg::WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial pins
  input wire logic selectPin_b,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic holdPin_b,
  input wire logic guardPin_b,
  output logic serialOut,
  output logic serialOutEn,
  // supply detector
  input wire logic lowSupply,
  // array write request
  output logic arrayWrStart,
  output logic [ewg_pkg::ADDR_W-1:0] arrayWrAddr,
  output logic writeRefused,
  // status view
  output logic statusLockBit,
  output logic protectSizeHi,
  output logic protectSizeLo,
  output logic writeEnableLatch,
  output logic writeInProgressFlag,
  output logic hardwareLockMode,
  output logic softwareLockMode,
  output logic holdActive
);
  import ewg_pkg::*;

  // ****************************************
  // protected address test
  // ****************************************
  function automatic logic isProtected(input logic [1:0] code,
                                       input logic [ADDR_W-1:0] addr);
    logic [1:0] top;
    top = WIDE64 ? addr[ADDR_W-1:ADDR_W-2] : addr[ADDR_W-2:ADDR_W-3];
    unique case (code)
      BP_NONE: isProtected = 1'b0;
      BP_QUARTER: isProtected = (top == 2'h3);
      BP_HALF: isProtected = top[1];
      BP_ALL: isProtected = 1'b1;
    endcase
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rstPipe;
  logic rstSync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe[1];

  // ****************************************
  // pin synchronisers
  // ****************************************
  // order: select, clock, data, hold, guard, supply
  logic [5:0] pinRaw;
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  logic sckPrev;
  logic selPrev_b;

  assign pinRaw = {selectPin_b, serialClk, serialIn, holdPin_b, guardPin_b, lowSupply};

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pinMeta <= 6'h24;
      pinSync <= 6'h24;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  logic selS_b;
  logic sckS;
  logic siS;
  logic holdS_b;
  logic guardS_b;
  logic lowS;

  assign selS_b = pinSync[5];
  assign sckS = pinSync[4];
  assign siS = pinSync[3];
  assign holdS_b = pinSync[2];
  assign guardS_b = pinSync[1];
  assign lowS = pinSync[0];

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      sckPrev <= 1'b0;
      selPrev_b <= 1'b1;
    end else begin
      sckPrev <= sckS;
      selPrev_b <= selS_b;
    end
  end

  logic sckRise;
  logic sckFall;
  logic deselect;
  logic selected;

  assign sckRise = sckS & ~sckPrev & ~holdActive;
  assign sckFall = ~sckS & sckPrev & ~holdActive;
  assign deselect = selS_b & ~selPrev_b;
  assign selected = ~selS_b;

  // ****************************************
  // hold control
  // ****************************************
  // the pause level is only taken while the clock is low, so a change
  // made with the clock high takes effect at the next falling edge
  logic next_holdActive;

  assign next_holdActive = !selected ? 1'b0 : (!sckS ? ~holdS_b : holdActive);

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      holdActive <= 1'b0;
    end else begin
      holdActive <= next_holdActive;
    end
  end

  // ****************************************
  // serial frame capture
  // ****************************************
  logic [5:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] opcode;
  logic [7:0] statusData;
  logic [ADDR_W-1:0] frameAddr;

  // the counter folds back to 32 each byte so long page frames stay small
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      bitCnt <= 6'h00;
    end else if (!selected) begin
      bitCnt <= 6'h00;
    end else if (sckRise) begin
      if (bitCnt + 6'h01 == LEN_ARRAY_WRAP) begin
        bitCnt <= LEN_ARRAY_HDR;
      end else begin
        bitCnt <= bitCnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      shiftIn <= 8'h00;
      opcode <= 8'h00;
      statusData <= 8'h00;
      frameAddr <= '0;
    end else if (selected && sckRise) begin
      shiftIn <= {shiftIn[6:0], siS};
      if (bitCnt + 6'h01 == LEN_SHORT_CMD) begin
        opcode <= {shiftIn[6:0], siS};
      end
      if (bitCnt + 6'h01 == LEN_STATUS_WRITE) begin
        statusData <= {shiftIn[6:0], siS};
      end
      if (bitCnt + 6'h01 == LEN_ADDR_END) begin
        frameAddr <= {statusData[ADDR_W-9:0], shiftIn[6:0], siS};
      end
    end
  end

  // ****************************************
  // protection decision
  // ****************************************
  logic hwLock;
  logic frameOk;
  logic isEnable;
  logic isDisable;
  logic isStatusWr;
  logic isArrayWr;
  logic statusAllowed;
  logic arrayAllowed;

  assign hwLock = statusLockBit & ~guardS_b;
  // a frame only counts when it ends by a clean deselect
  assign frameOk = deselect & ~holdActive & ~lowS;
  assign isEnable = frameOk && opcode == OP_WRITE_ENABLE && bitCnt == LEN_SHORT_CMD;
  assign isDisable = frameOk && opcode == OP_WRITE_DISABLE && bitCnt == LEN_SHORT_CMD;
  assign isStatusWr = frameOk && opcode == OP_STATUS_WRITE && bitCnt == LEN_STATUS_WRITE;
  assign isArrayWr = frameOk && opcode == OP_ARRAY_WRITE && bitCnt == LEN_ARRAY_HDR;
  // status write: open when unlocked or guard high, never in hardware lock
  assign statusAllowed = writeEnableLatch & ~hwLock & ~writeInProgressFlag;
  assign arrayAllowed = writeEnableLatch & ~writeInProgressFlag &
                        ~isProtected({protectSizeHi, protectSizeLo}, frameAddr);

  // ****************************************
  // write cycle
  // ****************************************
  logic [15:0] busyCnt;
  logic statusPending;
  logic [7:0] pendingData;
  logic busyDone;

  assign busyDone = writeInProgressFlag && busyCnt == 16'(WRITE_CYC - 1);

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      writeInProgressFlag <= 1'b0;
      busyCnt <= 16'h0000;
      statusPending <= 1'b0;
      pendingData <= 8'h00;
    end else if (lowS) begin
      writeInProgressFlag <= 1'b0;
      busyCnt <= 16'h0000;
      statusPending <= 1'b0;
    end else if (writeInProgressFlag) begin
      busyCnt <= busyCnt + 16'h0001;
      if (busyDone) begin
        writeInProgressFlag <= 1'b0;
        statusPending <= 1'b0;
      end
    end else if ((isStatusWr && statusAllowed) || (isArrayWr && arrayAllowed)) begin
      writeInProgressFlag <= 1'b1;
      busyCnt <= 16'h0000;
      statusPending <= isStatusWr;
      pendingData <= statusData;
    end
  end

  // nonvolatile bits keep old values until the cycle completes
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      statusLockBit <= RST_LOCK;
      protectSizeHi <= RST_BP[1];
      protectSizeLo <= RST_BP[0];
    end else if (busyDone && statusPending && !lowS) begin
      statusLockBit <= pendingData[SR_LOCK_POS];
      protectSizeHi <= pendingData[SR_BP_HI_POS];
      protectSizeLo <= pendingData[SR_BP_LO_POS];
    end
  end

  // ****************************************
  // write enable latch
  // ****************************************
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      writeEnableLatch <= 1'b0;
    end else if (lowS || busyDone || isDisable) begin
      writeEnableLatch <= 1'b0;
    end else if (isEnable && !writeInProgressFlag) begin
      writeEnableLatch <= 1'b1;
    end
  end

  // ****************************************
  // array request and refusal
  // ****************************************
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      arrayWrStart <= 1'b0;
      arrayWrAddr <= '0;
      writeRefused <= 1'b0;
    end else begin
      arrayWrStart <= isArrayWr & arrayAllowed;
      if (isArrayWr && arrayAllowed) begin
        arrayWrAddr <= frameAddr;
      end
      writeRefused <= ~writeInProgressFlag & ((isArrayWr & ~arrayAllowed) | (isStatusWr & ~statusAllowed));
    end
  end

  // ****************************************
  // mode view
  // ****************************************
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      hardwareLockMode <= 1'b0;
      softwareLockMode <= 1'b1;
    end else begin
      hardwareLockMode <= hwLock;
      softwareLockMode <= ~hwLock;
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  logic [7:0] statusByte;
  logic reading;

  always_comb begin
    statusByte = 8'h00;
    statusByte[SR_LOCK_POS] = statusLockBit;
    statusByte[SR_BP_HI_POS] = protectSizeHi;
    statusByte[SR_BP_LO_POS] = protectSizeLo;
    statusByte[SR_WEL_POS] = writeEnableLatch;
    statusByte[SR_WIP_POS] = writeInProgressFlag;
  end

  assign reading = selected && opcode == OP_STATUS_READ && bitCnt >= LEN_SHORT_CMD;

  // enable drops the moment a hold starts or the frame ends
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else begin
      if (reading && sckFall) begin
        serialOut <= statusByte[~bitCnt[2:0]];
      end
      if (!reading || next_holdActive) begin
        serialOutEn <= 1'b0;
      end else if (sckFall) begin
        serialOutEn <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== bench/ewg_write_guard_asserts.sv
// ewg_write_guard_asserts: port-level checks of the write guard
// assumes it is bound onto ewg_write_guard, one clk domain
`timescale 1ns/100ps
`default_nettype none
module ewg_write_guard_asserts #(
  parameter bit WIDE64 = 1'b1
) (
  // clock, reset and pins
  input wire logic clk,
  input wire logic rst_b,
  input wire logic selectPin_b,
  input wire logic lowSupply,
  // design outputs
  input wire logic arrayWrStart,
  input wire logic [ewg_pkg::ADDR_W-1:0] arrayWrAddr,
  input wire logic writeRefused,
  input wire logic statusLockBit,
  input wire logic protectSizeHi,
  input wire logic protectSizeLo,
  input wire logic writeEnableLatch,
  input wire logic writeInProgressFlag,
  input wire logic hardwareLockMode,
  input wire logic softwareLockMode,
  input wire logic serialOutEn,
  input wire logic holdActive
);
  import ewg_pkg::*;
  // ****************************************
  // checks
  // ****************************************
  logic [1:0] topBits;
  logic inRegion;
  assign topBits = WIDE64 ? arrayWrAddr[12:11] : arrayWrAddr[11:10];
  assign inRegion = (protectSizeHi && (protectSizeLo || topBits[1])) || (protectSizeLo && (&topBits));
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a refused frame must leave the device idle now and next cycle
  sequence quietBusy;
    !writeInProgressFlag ##1 !writeInProgressFlag;
  endsequence
  mode_view_a: assert property ((hardwareLockMode != softwareLockMode) && (!hardwareLockMode || statusLockBit))
    else $error("mode view wrong");
  hold_float_a: assert property (holdActive |-> !serialOutEn)
    else $error("output driven in hold");
  start_region_a: assert property (arrayWrStart |-> !inRegion)
    else $error("protected write started");
  start_armed_a: assert property (arrayWrStart |-> writeInProgressFlag && $past(writeEnableLatch))
    else $error("write without latch");
  start_selected_a: assert property (arrayWrStart |-> $past(selectPin_b, 3))
    else $error("write while selected");
  refuse_quiet_a: assert property (writeRefused |-> quietBusy)
    else $error("refused write went busy");
  busy_end_latch_a: assert property ($fell(writeInProgressFlag) |-> ##[0:1] !writeEnableLatch)
    else $error("latch kept after write");
  supply_cancel_a: assert property (lowSupply [*6] |-> !writeEnableLatch && !writeInProgressFlag)
    else $error("low supply ignored");
  lock_frozen_a: assert property ($past(hardwareLockMode) && !$past(writeInProgressFlag) && !writeInProgressFlag
    |-> $stable({statusLockBit, protectSizeHi, protectSizeLo}))
    else $error("status changed in lock");
endmodule
`default_nettype wire

// ===== bench/ewg_spi_host.sv
// ewg_spi_host: behavioural spi host for the write guard bench
// assumes mode 0 framing, serial clock idle low, 125 ns period
`timescale 1ns/100ps
`default_nettype none
module ewg_spi_host (
  // serial pins
  output var logic selectPin_b,
  output var logic serialClk,
  output var logic serialIn,
  output var logic holdPin_b,
  // bench view
  output var logic inHold
);
  // ****************************************
  // framing
  // ****************************************
  initial begin
    selectPin_b = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
    holdPin_b = 1'b1;
    inHold = 1'b0;
  end
  // low n bits of d go out msb first; drop deselects inside the hold
  task automatic frame(input logic [31:0] d, input int n, input int holdAt, input bit drop);
    selectPin_b = 1'b0;
    for (int i = 0; i < n; i++) begin
      serialIn = d[n - 1 - i];
      #62.5;
      if (i == holdAt) begin
        holdPin_b = 1'b0;
        inHold = 1'b1;
        #250;
        if (drop) begin
          selectPin_b = 1'b1;
          serialIn = ~serialIn;
          #100;
          holdPin_b = 1'b1;
          inHold = 1'b0;
          return;
        end
        holdPin_b = 1'b1;
        inHold = 1'b0;
        #62.5;
      end
      serialClk = 1'b1;
      #62.5;
      serialClk = 1'b0;
    end
    #62.5;
    selectPin_b = 1'b1;
    serialIn = ~serialIn;
    #30;
  endtask
endmodule
`default_nettype wire

// ===== bench/ewg_write_guard_bench.sv
// ewg_write_guard_bench: directed scenarios for the write guard
// assumes ewg_spi_host as far side, WRITE_CYC shortened
`timescale 1ns/100ps
`default_nettype none
module ewg_write_guard_bench;
  import ewg_pkg::*;
  // ****************************************
  // harness
  // ****************************************
  localparam int WCYC = 40;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic guardPin_b = 1'b1;
  logic lowSupply = 1'b0;
  wire logic selectPin_b, serialClk, serialIn, holdPin_b, inHold;
  logic serialOut, serialOutEn, arrayWrStart, writeRefused, statusLockBit, protectSizeHi, protectSizeLo;
  logic writeEnableLatch, writeInProgressFlag, hardwareLockMode, softwareLockMode, holdActive;
  logic [ADDR_W-1:0] arrayWrAddr, lastAddr;
  int errorCnt = 0;
  int checksDone = 0;
  int starts = 0;
  int refusals = 0;
  logic [7:0] readByte = 8'h00;
  always #2.5 clk = ~clk;
  // host-side capture of the status byte on each serial clock rise
  always @(posedge serialClk) begin
    if (serialOutEn === 1'b1) readByte <= {readByte[6:0], serialOut};
  end
  always @(posedge clk) begin
    if (arrayWrStart === 1'b1) begin
      starts <= starts + 1;
      lastAddr <= arrayWrAddr;
    end
    if (writeRefused === 1'b1) refusals <= refusals + 1;
  end
  ewg_spi_host i_host (.selectPin_b, .serialClk, .serialIn, .holdPin_b, .inHold);
  ewg_write_guard #(.WIDE64(1'b1), .WRITE_CYC(WCYC)) i_ewg_write_guard (.clk, .rst_b, .selectPin_b,
    .serialClk, .serialIn, .holdPin_b, .guardPin_b, .serialOut, .serialOutEn, .lowSupply, .arrayWrStart,
    .arrayWrAddr, .writeRefused, .statusLockBit, .protectSizeHi, .protectSizeLo, .writeEnableLatch,
    .writeInProgressFlag, .hardwareLockMode, .softwareLockMode, .holdActive);
  task automatic wrapUp();
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic write_enable_cmd();
    i_host.frame(32'h6, 8, -1, 1'b0);
    tick(10);
  endtask
  // one write frame, optionally armed first, judged by its pulses
  task automatic wr(input logic [31:0] d, input int n, input bit en, input bit ok);
    int s0, r0, i;
    if (en) write_enable_cmd();
    s0 = starts;
    r0 = refusals;
    i_host.frame(d, n, -1, 1'b0);
    tick(12);
    chk(16'(starts - s0), {15'h0, ok && n == 32});
    chk(16'(refusals - r0), {15'h0, !ok});
    for (i = 0; i < 200 && writeInProgressFlag !== 1'b0; i++) tick(1);
    if (i == 200) begin
      errorCnt++;
      wrapUp();
    end
    tick(6);
  endtask
  task automatic tLatch();
    chk({7'h0, softwareLockMode, hardwareLockMode, statusLockBit, protectSizeHi, protectSizeLo,
      writeEnableLatch, writeInProgressFlag, holdActive, serialOutEn}, 16'h100);
    wr({8'h2, 16'h0010, 8'hA5}, 32, 1'b0, 1'b0);
    wr({8'h2, 16'h1FFF, 8'h5A}, 32, 1'b1, 1'b1);
    chk(16'(lastAddr), 16'h1FFF);
    chk(16'(writeEnableLatch), 16'h0);
    write_enable_cmd();
    chk(16'(writeEnableLatch), 16'h1);
    i_host.frame(32'h0500, 16, -1, 1'b0);
    tick(10);
    chk(16'(readByte), 16'h02);
    i_host.frame(32'h4, 8, -1, 1'b0);
    tick(10);
    chk(16'(writeEnableLatch), 16'h0);
  endtask
  task automatic tRegions();
    logic [15:0] lo;
    for (int k = 1; k < 4; k++) begin
      lo = (k == 1) ? 16'h1800 : (k == 2) ? 16'h1000 : 16'h0000;
      wr({16'h0, 8'h1, 4'h0, 2'(k), 2'h0}, 16, 1'b1, 1'b1);
      chk(16'({protectSizeHi, protectSizeLo}), 16'(k));
      if (k < 3) wr({8'h2, lo - 16'h1, 8'h11}, 32, 1'b1, 1'b1);
      wr({8'h2, lo, 8'h22}, 32, 1'b1, 1'b0);
    end
  endtask
  task automatic tHwLock();
    guardPin_b = 1'b0;
    wr({16'h0, 8'h1, 8'h84}, 16, 1'b1, 1'b1);
    chk(16'(hardwareLockMode), 16'h1);
    i_host.frame(32'h0500, 16, -1, 1'b0);
    tick(10);
    chk(16'(readByte), 16'h84);
    wr({16'h0, 8'h1, 8'h00}, 16, 1'b1, 1'b0);
    chk(16'({statusLockBit, protectSizeHi, protectSizeLo}), 16'h5);
    wr({8'h2, 16'h17FF, 8'h33}, 32, 1'b1, 1'b1);
    wr({8'h2, 16'h1800, 8'h44}, 32, 1'b1, 1'b0);
    guardPin_b = 1'b1;
    tick(8);
    chk(16'(hardwareLockMode), 16'h0);
    wr({16'h0, 8'h1, 8'h88}, 16, 1'b1, 1'b1);
    chk(16'({statusLockBit, protectSizeHi, protectSizeLo}), 16'h6);
    wr({16'h0, 8'h1, 8'h00}, 16, 1'b1, 1'b1);
  endtask
  task automatic tHold();
    int i;
    fork
      i_host.frame({16'h0, 8'h5, 8'h0}, 16, 10, 1'b0);
      begin
        for (i = 0; i < 4000 && inHold !== 1'b1; i++) tick(1);
        if (i == 4000) begin
          errorCnt++;
          wrapUp();
        end
        tick(8);
        chk(16'({holdActive, serialOutEn}), 16'h2);
      end
    join
    tick(10);
    // full enable opcode, then deselect while paused: must be abandoned
    i_host.frame(32'hC, 9, 8, 1'b1);
    tick(10);
    chk(16'({holdActive, writeEnableLatch}), 16'h0);
  endtask
  task automatic tSupply();
    write_enable_cmd();
    i_host.frame({8'h2, 16'h0020, 8'h55}, 32, -1, 1'b0);
    tick(12);
    chk(16'(writeInProgressFlag), 16'h1);
    lowSupply = 1'b1;
    tick(8);
    chk(16'({writeInProgressFlag, writeEnableLatch}), 16'h0);
    lowSupply = 1'b0;
    tick(10);
    wr({8'h2, 16'h0020, 8'h55}, 32, 1'b0, 1'b0);
    wr({8'h2, 16'h0020, 8'h55}, 32, 1'b1, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    tick(12);
    tLatch();
    tRegions();
    tHwLock();
    tHold();
    tSupply();
    wrapUp();
  end
  initial begin
    #400000;
    errorCnt++;
    wrapUp();
  end
endmodule
bind ewg_write_guard ewg_write_guard_asserts #(.WIDE64(WIDE64)) i_asserts (.clk, .rst_b, .selectPin_b,
  .lowSupply, .arrayWrStart, .arrayWrAddr, .writeRefused, .statusLockBit, .protectSizeHi, .protectSizeLo,
  .writeEnableLatch, .writeInProgressFlag, .hardwareLockMode, .softwareLockMode, .serialOutEn, .holdActive);
`default_nettype wire
